// ---- crcu_top.sv ----
// checksum calculation unit with its register set
`timescale 1ns/1ns
module crcu_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register access, request held until acknowledge
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [7:0] reg_addr,
  input wire logic [1:0] reg_size,
  input wire logic [31:0] reg_wdata,
  // register answer
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err
);
  typedef enum logic [0:0] {ENG_IDLE, ENG_RUN} crcu_eng_t;

  // ==========================================================
  // state
  logic [31:0] crc_q, crc_d;
  logic [7:0] scratch_q, scratch_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [31:0] start_q, start_d;
  logic [31:0] gen_q, gen_d;
  crcu_eng_t eng_q, eng_d;
  logic [31:0] cur_q, cur_d;
  logic [2:0] left_q, left_d;
  logic buf_vld_q, buf_vld_d;
  logic [31:0] buf_q, buf_d;
  logic [2:0] buf_n_q, buf_n_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic err_q, err_d;
  logic [31:0] step_out;

  // ==========================================================
  // byte engine, top byte of the current word each cycle
  crcu_byte_step u_step (
    .crc_in(crc_q),
    .data_in(cur_q[31:24]),
    .generator_bits(gen_q),
    .generator_width(ctrl_q[crcu_pkg::CTRL_GW_HI:crcu_pkg::CTRL_GW_LO]),
    .crc_out(step_out)
  );

  // left-aligned, reversed input word for a data write
  function automatic logic [31:0] prep_input(input logic [31:0] d, input logic [1:0] sz, input logic [1:0] mode);
    logic [31:0] r;
    int x;
    r = d;
    // input reversal; xor on the bit index flips order inside each chunk
    case (mode)
      crcu_pkg::FLIP_BYTE: x = 7;
      crcu_pkg::FLIP_HALF: x = 15;
      crcu_pkg::FLIP_WORD: x = 31;
      default: x = 0;
    endcase
    // chunk never wider than the written data
    if (sz == crcu_pkg::SZ_HALF && x > 15) begin
      x = 15;
    end else if (sz == crcu_pkg::SZ_BYTE && x > 7) begin
      x = 7;
    end
    for (int i = 0; i < 32; i++) begin
      r[i] = d[i ^ x];
    end
    if (sz == crcu_pkg::SZ_HALF) begin
      r = {r[15:0], 16'h0000};
    end else if (sz == crcu_pkg::SZ_BYTE) begin
      r = {r[7:0], 24'h00_0000};
    end
    return r;
  endfunction

  // ==========================================================
  // next state of registers, engine and bus answer
  always_comb begin
    logic hit;
    logic word_ok;
    logic [2:0] steps;
    logic [31:0] prepped;
    logic eng_free;
    crc_d = crc_q;
    scratch_d = scratch_q;
    ctrl_d = ctrl_q;
    start_d = start_q;
    gen_d = gen_q;
    eng_d = eng_q;
    cur_d = cur_q;
    left_d = left_q;
    buf_vld_d = buf_vld_q;
    buf_d = buf_q;
    buf_n_d = buf_n_q;
    rdata_d = 32'h0000_0000;
    ack_d = 1'b0;
    err_d = 1'b0;
    eng_free = 1'b0;
    hit = reg_req && !ack_q;
    word_ok = (reg_size == crcu_pkg::SZ_WORD);
    steps = crcu_pkg::STEPS_WORD;
    if (reg_size == crcu_pkg::SZ_HALF) begin
      steps = crcu_pkg::STEPS_HALF;
    end else if (reg_size == crcu_pkg::SZ_BYTE) begin
      steps = crcu_pkg::STEPS_BYTE;
    end
    prepped = prep_input(reg_wdata, reg_size, ctrl_q[crcu_pkg::CTRL_FLIP_IN_HI:crcu_pkg::CTRL_FLIP_IN_LO]);

    // one byte per cycle, combine byte by byte
    // free also on the last byte with nothing buffered, so a write then starts at once
    if (eng_q == ENG_RUN) begin
      crc_d = step_out;
      cur_d = {cur_q[23:0], 8'h00};
      left_d = left_q - 3'd1;
      if (left_q == 3'd1) begin
        if (buf_vld_q) begin
          cur_d = buf_q;
          left_d = buf_n_q;
          buf_vld_d = 1'b0;
        end else begin
          eng_d = ENG_IDLE;
          eng_free = 1'b1;
        end
      end
    end else begin
      eng_free = 1'b1;
    end

    if (hit) begin
      case (reg_addr)
        crcu_pkg::OFF_DATA: begin
          if (reg_size > crcu_pkg::SZ_WORD) begin
            ack_d = 1'b1;
            err_d = 1'b1;
          end else if (reg_we) begin
            // feed written value, input buffer absorbs one extra write
            // buffering on the last byte would strand the word with the engine idle
            if (eng_free) begin
              eng_d = ENG_RUN;
              cur_d = prepped;
              left_d = steps;
              ack_d = 1'b1;
            end else if (!buf_vld_q) begin
              buf_vld_d = 1'b1;
              buf_d = prepped;
              buf_n_d = steps;
              ack_d = 1'b1;
            end
          end else if (eng_q == ENG_IDLE) begin
            ack_d = 1'b1;
            if (ctrl_q[crcu_pkg::CTRL_FLIP_OUT]) begin
              rdata_d = crcu_pkg::rev_low(crc_q, crcu_pkg::gen_bits(ctrl_q[crcu_pkg::CTRL_GW_HI:crcu_pkg::CTRL_GW_LO]));
            end else begin
              rdata_d = crc_q;
            end
          end
        end
        crcu_pkg::OFF_SCRATCH: begin
          ack_d = 1'b1;
          err_d = !word_ok;
          if (word_ok && reg_we) begin
            scratch_d = reg_wdata[7:0];
          end
          rdata_d = {24'h00_0000, scratch_q};
        end
        crcu_pkg::OFF_CTRL: begin
          ack_d = 1'b1;
          err_d = !word_ok;
          if (word_ok && reg_we) begin
            ctrl_d = reg_wdata[7:0] & crcu_pkg::CTRL_WR_MASK;
            // set-only reset, cleared at once; scratch untouched
            if (reg_wdata[crcu_pkg::CTRL_RESET]) begin
              crc_d = start_q;
              eng_d = ENG_IDLE;
              left_d = 3'd0;
              buf_vld_d = 1'b0;
            end
          end
          rdata_d = {24'h00_0000, ctrl_q};
        end
        crcu_pkg::OFF_START: begin
          ack_d = 1'b1;
          err_d = !word_ok;
          // start value, immediate load into checksum
          if (word_ok && reg_we) begin
            start_d = reg_wdata;
            crc_d = reg_wdata;
            eng_d = ENG_IDLE;
            left_d = 3'd0;
            buf_vld_d = 1'b0;
          end
          rdata_d = start_q;
        end
        crcu_pkg::OFF_GEN: begin
          ack_d = 1'b1;
          err_d = !word_ok;
          if (word_ok && reg_we) begin
            gen_d = reg_wdata;
          end
          rdata_d = gen_q;
        end
        default: begin
          // unmapped offset answers with error and zero
          ack_d = 1'b1;
          err_d = 1'b1;
        end
      endcase
      if (err_d) begin
        rdata_d = 32'h0000_0000;
      end
    end
    if (!ack_d || reg_we) begin
      rdata_d = (ack_d && !reg_we) ? rdata_d : 32'h0000_0000;
    end
  end

  // ==========================================================
  // registers only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      crc_q <= crcu_pkg::RST_DATA;
      scratch_q <= crcu_pkg::RST_SCRATCH;
      ctrl_q <= crcu_pkg::RST_CTRL;
      start_q <= crcu_pkg::RST_START;
      gen_q <= crcu_pkg::RST_GEN;
      eng_q <= ENG_IDLE;
      cur_q <= 32'h0000_0000;
      left_q <= 3'd0;
      buf_vld_q <= 1'b0;
      buf_q <= 32'h0000_0000;
      buf_n_q <= 3'd0;
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      crc_q <= crc_d;
      scratch_q <= scratch_d;
      ctrl_q <= ctrl_d;
      start_q <= start_d;
      gen_q <= gen_d;
      eng_q <= eng_d;
      cur_q <= cur_d;
      left_q <= left_d;
      buf_vld_q <= buf_vld_d;
      buf_q <= buf_d;
      buf_n_q <= buf_n_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      err_q <= err_d;
    end
  end

  // answer straight from flops
  assign reg_rdata = rdata_q;
  assign reg_ack = ack_q;
  assign reg_err = err_q;
endmodule

// ---- crcu_pkg.sv ----
// constants, field layout and helpers of the checksum calculation unit
// Behaviour
// - data register writes feed the checksum; reads return latest result; resets all ones
// - narrower data sizes use the low-order bits of the data register
// - 8-bit scratch byte in bits 7:0, upper bits reserved, resets to zero
// - scratch byte survives the control-triggered checksum reset
// - control bit 7 bit-reverses the result read back
// - control bits 6:5 pick input reversal: none, byte, half-word, word
// - control bits 4:3 pick generator width: 32, 16, 8 or 7 bits
// - writing one to control bit 0 reloads checksum from start value
// - reset bit only settable, hardware clears it, writing zero does nothing
// - 32-bit start value register, resets all ones, seeds each computation
// - 32-bit generator register, resets to 0x04C11DB7, used for all computation
// - any start value write loads it immediately as the running checksum
// - word write takes 4 cycles, half-word 2, byte 1
// - data register takes word, half, byte accesses; others word only
// - each write combines previous checksum with input, byte by byte
package crcu_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_SCRATCH = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_START = 8'h10;
  localparam logic [7:0] OFF_GEN = 8'h14;
  // ==========================================================
  // reset values
  localparam logic [31:0] RST_DATA = 32'hFFFF_FFFF;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [31:0] RST_START = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_GEN = 32'h04C1_1DB7;
  // ==========================================================
  // control fields
  localparam int CTRL_FLIP_OUT = 7;
  localparam int CTRL_FLIP_IN_HI = 6;
  localparam int CTRL_FLIP_IN_LO = 5;
  localparam int CTRL_GW_HI = 4;
  localparam int CTRL_GW_LO = 3;
  localparam int CTRL_RESET = 0;
  localparam logic [7:0] CTRL_WR_MASK = 8'hF8;
  // input reversal modes
  localparam logic [1:0] FLIP_NONE = 2'b00;
  localparam logic [1:0] FLIP_BYTE = 2'b01;
  localparam logic [1:0] FLIP_HALF = 2'b10;
  localparam logic [1:0] FLIP_WORD = 2'b11;
  // generator widths
  localparam logic [1:0] GW_32 = 2'b00;
  localparam logic [1:0] GW_16 = 2'b01;
  localparam logic [1:0] GW_8 = 2'b10;
  localparam logic [1:0] GW_7 = 2'b11;
  // access sizes
  localparam logic [1:0] SZ_BYTE = 2'b00;
  localparam logic [1:0] SZ_HALF = 2'b01;
  localparam logic [1:0] SZ_WORD = 2'b10;
  // bytes per access, one engine cycle each
  localparam logic [2:0] STEPS_BYTE = 3'd1;
  localparam logic [2:0] STEPS_HALF = 3'd2;
  localparam logic [2:0] STEPS_WORD = 3'd4;

  // ==========================================================
  // number of significant bits for a generator width code
  function automatic int gen_bits(input logic [1:0] code);
    int n;
    n = 32;
    case (code)
      GW_16: n = 16;
      GW_8: n = 8;
      GW_7: n = 7;
      default: n = 32;
    endcase
    return n;
  endfunction

  // reverse the low n bits, zero above
  function automatic logic [31:0] rev_low(input logic [31:0] x, input int n);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (i < n) begin
        r[i] = x[n - 1 - i];
      end
    end
    return r;
  endfunction
endpackage

// ---- crcu_byte_step.sv ----
// one byte of msb-first checksum division
`timescale 1ns/1ns
module crcu_byte_step (
  // running value and input
  input wire logic [31:0] crc_in,
  input wire logic [7:0] data_in,
  // generator setup
  input wire logic [31:0] generator_bits,
  input wire logic [1:0] generator_width,
  // result
  output logic [31:0] crc_out
);
  // ==========================================================
  // eight shift steps; unrolled by the tool, fits one cycle at 50 MHz
  always_comb begin
    logic [31:0] c;
    logic [31:0] mask;
    logic fb;
    int w;
    c = crc_in;
    w = crcu_pkg::gen_bits(generator_width);
    mask = (w == 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << w) - 32'h0000_0001);
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[w - 1] ^ data_in[i];
      c = (c << 1) & mask;
      if (fb) begin
        c = c ^ (generator_bits & mask);
      end
    end
    crc_out = c & mask;
  end
endmodule

// ---- crcu_top_asserts.sv ----
// assertion checker for the checksum unit register port
`timescale 1ns/1ns
module crcu_top_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // request side
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [7:0] reg_addr,
  input wire logic [1:0] reg_size,
  input wire logic [31:0] reg_wdata,
  // answer side
  input wire logic [31:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic reg_err
);
  // ==========================================================
  // taking of a request
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ack is registered, so a held request is only taken while ack is low
  sequence s_take;
    reg_req && !reg_ack;
  endsequence
  sequence s_reg_take;
    s_take ##0 reg_addr != 8'h00;
  endsequence
  // ==========================================================
  // answers
  a_ack_pulse: assert property (reg_ack |=> !reg_ack) else $error("ack longer than one cycle");
  a_err_with_ack: assert property (reg_err |-> reg_ack) else $error("err without ack");
  a_spurious_ack: assert property (reg_ack |-> $past(reg_req)) else $error("ack without request");
  a_rdata_idle: assert property (!reg_ack || reg_we |-> reg_rdata == 32'h0000_0000) else $error("rdata not zero");
  a_reg_one_cycle: assert property (s_reg_take |=> reg_ack) else $error("register answer late");
  a_data_bounded: assert property (s_take ##0 reg_addr == 8'h00 |-> ##[1:9] reg_ack) else $error("data stall");
  a_narrow_refused: assert property (s_reg_take ##0 reg_size != 2'b10 |=> reg_err) else $error("narrow access ok");
  a_unmapped_err: assert property (s_take ##0 !(reg_addr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14})
    |=> reg_err) else $error("unmapped access ok");
  a_scratch_upper: assert property (reg_ack && !reg_we && reg_addr == 8'h04 |-> reg_rdata[31:8] == 24'h00_0000)
    else $error("scratch upper bits set");
  a_ctrl_reserved: assert property (reg_ack && reg_addr == 8'h08 |-> reg_rdata[2:0] == 3'h0 && reg_rdata[31:8] == 24'h0)
    else $error("control reset bit reads set");
endmodule
bind crcu_top crcu_top_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_we(reg_we),
  .reg_addr(reg_addr), .reg_size(reg_size), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .reg_err(reg_err));

// ---- crc_calculation_unit_tb.sv ----
// self-checking bench for the checksum unit
`timescale 1ns/1ns
module crc_calculation_unit_tb;
  // ==========================================================
  // port signals and model state
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_req = 1'b0;
  logic reg_we = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [1:0] reg_size = 2'b10;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic reg_ack;
  logic reg_err;
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'h91fd;
  logic [31:0] v;
  logic [32:0] exp_q[$];
  logic [7:0] offs[5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
  logic [31:0] crc_m = 32'hFFFF_FFFF;
  logic [31:0] start_m = 32'hFFFF_FFFF;
  logic [31:0] pol_m = 32'h04C1_1DB7;
  logic [7:0] ctrl_m = 8'h00;
  logic [7:0] scr_m = 8'h00;

  crcu_top dut_u (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr),
    .reg_size(reg_size), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err));

  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end

  // reverse the low n bits, zero above
  function automatic logic [31:0] rv(logic [31:0] x, int n);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < n; i++) r[i] = x[n - 1 - i];
    return r;
  endfunction

  function automatic int wid(logic [1:0] c);
    return (c == 2'b11) ? 7 : 32 >> c;
  endfunction

  // reversal chunk capped at write width, then msb-first division
  function automatic logic [31:0] step(logic [31:0] c, logic [31:0] d, int nb);
    int u;
    int w;
    logic [31:0] r;
    logic [63:0] msk;
    logic fb;
    u = (ctrl_m[6:5] == 2'b00) ? 1 : 4 << ctrl_m[6:5];
    if (u > nb * 8) u = nb * 8;
    w = wid(ctrl_m[4:3]);
    msk = (64'h1 << w) - 64'h1;
    for (int i = 0; i < nb * 8; i++) r[i] = d[(i / u) * u + u - 1 - i % u];
    for (int i = nb * 8 - 1; i >= 0; i--) begin
      fb = c[w - 1] ^ r[i];
      c = ((c << 1) ^ (fb ? pol_m : 32'h0000_0000)) & msk[31:0];
    end
    return c;
  endfunction

  task automatic chk(logic [32:0] seen, logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one access: note the expected answer, hold the request until ack is sampled
  task automatic acc(logic we, logic [7:0] a, logic [1:0] sz, logic [31:0] wd);
    logic e;
    logic [31:0] x;
    int n;
    e = !(a inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14}) || (a != 8'h00 && sz != 2'b10) || sz == 2'b11;
    x = 32'h0000_0000;
    if (!e && we) begin
      case (a)
        8'h00: crc_m = step(crc_m, wd, 1 << sz);
        8'h04: scr_m = wd[7:0];
        8'h08: begin
          ctrl_m = wd[7:0] & 8'hF8;
          if (wd[0]) crc_m = start_m;
        end
        8'h10: begin
          start_m = wd;
          crc_m = wd;
        end
        default: pol_m = wd;
      endcase
    end else if (!e) begin
      case (a)
        8'h00: x = ctrl_m[7] ? rv(crc_m, wid(ctrl_m[4:3])) : crc_m;
        8'h04: x = {24'h00_0000, scr_m};
        8'h08: x = {24'h00_0000, ctrl_m};
        8'h10: x = start_m;
        default: x = pol_m;
      endcase
    end
    exp_q.push_back({e, x});
    @(posedge clk);
    #2;
    {reg_req, reg_we, reg_addr, reg_size, reg_wdata} = {1'b1, we, a, sz, wd};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (reg_ack !== 1'b1 && n < 20);
    if (reg_ack !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
    #2;
    reg_req = 1'b0;
  endtask

  // scoreboard: each ack takes the oldest noted answer
  always @(posedge clk) begin
    if (reg_ack === 1'b1) begin
      chk({reg_err, reg_rdata}, exp_q.size() > 0 ? exp_q.pop_front() : 33'h1_FFFF_FFFF);
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    for (int i = 0; i < 5; i++) acc(1'b0, offs[i], 2'b10, 32'h0000_0000);
    v = $random(seed);
    acc(1'b1, 8'h04, 2'b10, {24'h00_0000, v[7:0]});
    acc(1'b0, 8'h04, 2'b10, 32'h0000_0000);
    // every output flip, input flip and width setting, back-to-back writes
    for (int m = 0; m < 32; m++) begin
      v = $random(seed);
      acc(1'b1, 8'h08, 2'b10, {24'h00_0000, m[4:0], 3'b000});
      acc(1'b1, 8'h14, 2'b10, v | 32'h0000_0001);
      acc(1'b1, 8'h10, 2'b10, v ^ 32'h5A5A_5A5A);
      if (!m[4]) acc(1'b0, 8'h00, 2'b10, 32'h0000_0000);
      for (int s = 2; s >= 0; s--) acc(1'b1, 8'h00, s[1:0], $random(seed));
      acc(1'b0, 8'h00, 2'b10, 32'h0000_0000);
    end
    // control reset reloads the start value and spares the scratch byte
    acc(1'b1, 8'h00, 2'b10, v);
    acc(1'b1, 8'h08, 2'b10, 32'h0000_0011);
    acc(1'b0, 8'h08, 2'b10, 32'h0000_0000);
    acc(1'b0, 8'h00, 2'b10, 32'h0000_0000);
    acc(1'b0, 8'h04, 2'b10, 32'h0000_0000);
    acc(1'b1, 8'h00, 2'b00, v);
    acc(1'b1, 8'h08, 2'b10, 32'h0000_0010);
    acc(1'b0, 8'h00, 2'b10, 32'h0000_0000);
    // refused accesses leave no trace
    acc(1'b1, 8'h04, 2'b01, 32'h0000_00FF);
    acc(1'b1, 8'h0C, 2'b10, v);
    acc(1'b1, 8'h00, 2'b11, v);
    acc(1'b0, 8'h04, 2'b10, 32'h0000_0000);
    acc(1'b0, 8'h00, 2'b10, 32'h0000_0000);
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule
